// ### rtl/pcd_port.sv
// panel and crt display output port with its pixel fifo
// What this block does
// - refresh disable input low stops all screen refresh activity.
// - display type output high in crt mode, low in lcd mode.
// - shift clock shifts upper and lower data, lcd and plasma.
// - weight clock for gray pwm in lcd, video enable in plasma.
// - line latch pulse in lcd, horizontal sync in plasma and crt.
// - frame pulse in lcd, vertical sync in plasma and crt.
// - frame toggle flips each lcd frame, is blank in crt.
// - lower data is lcd lower bus, reserved plasma, low pixel bits crt.
// - upper data is lcd upper bus, plasma video, high pixel bits crt.
// - pixel clock clocks pixel outputs into ramdac in crt mode.
// - palette read strobe low on reads of 3c6, 3c8, 3c9 only.
// - palette write strobe low on writes within 3c6 to 3c9.
// - both palette strobes work with internal or external ramdac.
// - color tft mode turns palette read into ninth pixel bit.
// - grounded reference disables ramdac, pin becomes monitor sense.
// - monitor sense level returned in bit 4 of 3c2 reads.
`include "pcd_cfg.svh"

// dual clock fifo, gray pointers cross the domains
module pcd_fifo #(
	parameter int WIDTH = `PCD_PIX_W,
	parameter int DEPTH = `PCD_FIFO_DEPTH
) (
	// write side
	input wire logic i_wr_clk,
	input wire logic i_wr_rst_n,
	input wire logic i_wr_ce,
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	// read side
	input wire logic i_rd_clk,
	input wire logic i_rd_rst_n,
	input wire logic i_rd_ce,
	input wire logic i_ready,
	output logic o_valid,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	typedef logic [AW:0] pcd_ptr_t;
	typedef struct packed {
		pcd_ptr_t bin;
		pcd_ptr_t gray;
		pcd_ptr_t s1;
		pcd_ptr_t s2;
		logic flag;
	} pcd_side_t;

	pcd_side_t w, next_w, r, next_r;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pull;

	function automatic pcd_ptr_t pcd_gray(input pcd_ptr_t b);
		return b ^ (b >> 1);
	endfunction : pcd_gray

	// flag is full on the write side, not-empty on the read side
	assign push = i_wr_ce && i_valid && !w.flag;
	assign pull = i_rd_ce && i_ready && r.flag;
	assign o_ready = !w.flag;
	assign o_valid = r.flag;
	assign o_data = mem[r.bin[AW-1:0]];

	// write pointer; full is judged against the stale read pointer
	always_comb begin
		next_w = w;
		if (!i_wr_rst_n) begin
			next_w = '0;
		end else if (i_wr_ce) begin
			next_w.s1 = r.gray;
			next_w.s2 = w.s1;
			next_w.bin = w.bin + pcd_ptr_t'(push);
			next_w.gray = pcd_gray(next_w.bin);
			next_w.flag = next_w.gray ==
				{~w.s2[AW:AW-1], w.s2[AW-2:0]};
		end
	end

	// read pointer; empty only clears once the write pointer arrives
	always_comb begin
		next_r = r;
		if (!i_rd_rst_n) begin
			next_r = '0;
		end else if (i_rd_ce) begin
			next_r.s1 = w.gray;
			next_r.s2 = r.s1;
			next_r.bin = r.bin + pcd_ptr_t'(pull);
			next_r.gray = pcd_gray(next_r.bin);
			next_r.flag = next_r.gray != r.s2;
		end
	end

	always_ff @(posedge i_wr_clk) begin
		w <= next_w;
		if (push) begin
			mem[w.bin[AW-1:0]] <= i_data;
		end
	end

	always_ff @(posedge i_rd_clk) begin
		r <= next_r;
	end
endmodule : pcd_fifo

// display port top
module pcd_port #(
	parameter logic [`PCD_CNT_W-1:0] H_ACT = `PCD_H_ACT,
	parameter logic [`PCD_CNT_W-1:0] H_TOT = `PCD_H_TOT,
	parameter logic [`PCD_CNT_W-1:0] HS_START = `PCD_HS_START,
	parameter logic [`PCD_CNT_W-1:0] HS_LEN = `PCD_HS_LEN,
	parameter logic [`PCD_CNT_W-1:0] V_ACT = `PCD_V_ACT,
	parameter logic [`PCD_CNT_W-1:0] V_TOT = `PCD_V_TOT,
	parameter logic [`PCD_CNT_W-1:0] VS_START = `PCD_VS_START,
	parameter logic [`PCD_CNT_W-1:0] VS_LEN = `PCD_VS_LEN,
	parameter int FIFO_DEPTH = `PCD_FIFO_DEPTH
) (
	// system clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// link clock that paces the panel side
	input wire logic i_link_clk,
	// configuration
	input wire pcd_pkg::pcd_mode_t i_display_mode,
	input wire logic i_color_tft,
	// pins
	input wire logic i_refresh_disable_n,
	input wire logic i_vref_grounded,
	input wire logic i_monitor_sense_scale_adj,
	// host io cycle
	input wire logic [`PCD_ADDR_W-1:0] i_io_addr,
	input wire logic i_io_rd,
	input wire logic i_io_wr,
	output logic o_stat_valid,
	output logic [7:0] o_stat_data,
	// pixel stream in
	input wire logic i_pix_valid,
	input wire pcd_pkg::pcd_pix_t i_pix,
	output logic o_pix_ready,
	// display pins
	output logic o_display_type_select,
	output logic o_column_shift_clock,
	output logic o_gray_weight_clock,
	output logic o_line_latch_hsync,
	output logic o_frame_start_vsync,
	output logic o_frame_toggle_blank,
	output logic [3:0] o_lower_half_data,
	output logic [3:0] o_upper_half_data,
	output logic o_pixel_clock,
	output logic o_palette_read_n,
	output logic o_palette_write_n
);
	pcd_pkg::pcd_sys_t s, next_s;
	pcd_pkg::pcd_link_t lk, next_lk;
	pcd_pkg::pcd_pix_t fifo_pix;
	logic fifo_valid, fifo_ready, pop;

	// pixel words cross to the link clock through the fifo
	pcd_fifo #(
		.WIDTH(`PCD_PIX_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_wr_clk(i_sys_clk),
		.i_wr_rst_n(i_rst_n),
		.i_wr_ce(i_clk_en),
		.i_valid(i_pix_valid),
		.i_data(i_pix),
		.o_ready(fifo_ready),
		.i_rd_clk(i_link_clk),
		.i_rd_rst_n(lk.rst_s2),
		.i_rd_ce(lk.ce_s2),
		.i_ready(pop),
		.o_valid(fifo_valid),
		.o_data(fifo_pix)
	);

	// system side: strobes, status read, mode register
	always_comb begin
		next_s = s;
		next_s.rst_q = i_rst_n;
		next_s.ce_q = i_clk_en;
		if (!i_rst_n) begin
			next_s.vref_s1 = 1'b0;
			next_s.vref_s2 = 1'b0;
			next_s.sense_s1 = 1'b0;
			next_s.sense_s2 = 1'b0;
			next_s.rd_hit = 1'b0;
			next_s.wr_n = 1'b1;
			next_s.type_sel = 1'b0;
			next_s.mode_q = pcd_pkg::PCD_LCD;
			next_s.tft_q = 1'b0;
			next_s.rvalid = 1'b0;
			next_s.rdata = 8'h00;
		end else if (i_clk_en) begin
			next_s.vref_s1 = i_vref_grounded;
			next_s.vref_s2 = s.vref_s1;
			next_s.sense_s1 = i_monitor_sense_scale_adj;
			next_s.sense_s2 = s.sense_s1;
			// 3c7 is left out of the read decode on purpose
			next_s.rd_hit = i_io_rd &&
				(i_io_addr == `PCD_DAC_MASK ||
				i_io_addr == `PCD_DAC_WINDEX ||
				i_io_addr == `PCD_DAC_DATA);
			next_s.wr_n = !(i_io_wr &&
				i_io_addr >= `PCD_DAC_MASK &&
				i_io_addr <= `PCD_DAC_DATA);
			next_s.type_sel =
				i_display_mode == pcd_pkg::PCD_CRT;
			next_s.mode_q = i_display_mode;
			next_s.tft_q = i_color_tft;
			next_s.rvalid = i_io_rd && i_io_addr == `PCD_IN_STAT0;
			next_s.rdata = 8'h00;
			// sense only means something with the dac disabled
			next_s.rdata[`PCD_SENSE_BIT] =
				s.vref_s2 && s.sense_s2;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		s <= next_s;
	end

	// link side: raster timing and per-mode pin functions
	always_comb begin
		logic [`PCD_CNT_W-1:0] hn;
		logic [`PCD_CNT_W-1:0] vn;
		logic eol, act_n, hs, vs;
		pcd_pkg::pcd_pix_t pix;
		hn = '0;
		vn = '0;
		eol = 1'b0;
		act_n = 1'b0;
		hs = 1'b0;
		vs = 1'b0;
		pix = '0;
		pop = 1'b0;
		next_lk = lk;
		// synchronisers always run, even while frozen
		next_lk.rst_s1 = s.rst_q;
		next_lk.rst_s2 = lk.rst_s1;
		next_lk.ce_s1 = s.ce_q;
		next_lk.ce_s2 = lk.ce_s1;
		next_lk.mode_s1 = s.mode_q;
		next_lk.mode_s2 = lk.mode_s1;
		next_lk.tft_s1 = s.tft_q;
		next_lk.tft_s2 = lk.tft_s1;
		next_lk.ref_s1 = i_refresh_disable_n;
		next_lk.ref_s2 = lk.ref_s1;
		next_lk.rd_s1 = s.rd_hit;
		next_lk.rd_s2 = lk.rd_s1;
		if (!lk.rst_s2) begin
			// park on the last slot so the first frame starts at pixel 0
			next_lk.hcnt = H_TOT - `PCD_CNT_ONE;
			next_lk.vcnt = V_TOT - `PCD_CNT_ONE;
			next_lk.phase = 1'b0;
			next_lk.act = 1'b0;
			next_lk.frame_odd = 1'b0;
			next_lk.weight_q = 1'b0;
			next_lk.sck = 1'b0;
			next_lk.pclk = 1'b0;
			next_lk.wgt = 1'b0;
			next_lk.latch = 1'b0;
			next_lk.fpv = 1'b0;
			next_lk.ftb = 1'b0;
			next_lk.up = 4'h0;
			next_lk.lo = 4'h0;
			next_lk.bit9 = 1'b0;
			next_lk.prd_n = 1'b1;
		end else if (lk.ce_s2) begin
			if (!lk.ref_s2) begin
				// power down: raster parked, no fetches
				next_lk.hcnt = H_TOT - `PCD_CNT_ONE;
				next_lk.vcnt = V_TOT - `PCD_CNT_ONE;
				next_lk.phase = 1'b0;
				next_lk.act = 1'b0;
				next_lk.sck = 1'b0;
				next_lk.pclk = 1'b0;
				next_lk.wgt = 1'b0;
				next_lk.latch = 1'b0;
				next_lk.fpv = 1'b0;
				next_lk.up = 4'h0;
				next_lk.lo = 4'h0;
				next_lk.bit9 = 1'b0;
			end else if (!lk.phase) begin
				// rising edge: panel and ramdac sample here
				next_lk.phase = 1'b1;
				next_lk.sck = lk.act &&
					lk.mode_s2 != pcd_pkg::PCD_CRT;
				next_lk.pclk =
					lk.mode_s2 == pcd_pkg::PCD_CRT;
			end else begin
				// falling edge: data moves, clocks drop
				next_lk.phase = 1'b0;
				next_lk.sck = 1'b0;
				next_lk.pclk = 1'b0;
				eol = lk.hcnt == H_TOT - `PCD_CNT_ONE;
				hn = eol ? '0 : lk.hcnt + `PCD_CNT_ONE;
				vn = lk.vcnt;
				if (eol) begin
					vn = (lk.vcnt == V_TOT - `PCD_CNT_ONE) ?
						'0 : lk.vcnt + `PCD_CNT_ONE;
				end
				act_n = hn < H_ACT && vn < V_ACT;
				// an empty fifo shows black, nothing stalls
				pop = act_n && fifo_valid;
				pix = pop ? fifo_pix : '0;
				hs = hn >= HS_START && hn < HS_START + HS_LEN;
				vs = vn >= VS_START && vn < VS_START + VS_LEN;
				next_lk.hcnt = hn;
				next_lk.vcnt = vn;
				next_lk.act = act_n;
				next_lk.latch = hs;
				next_lk.fpv = vs;
				if (eol && vn == VS_START) begin
					next_lk.frame_odd = !lk.frame_odd;
				end
				if (eol) begin
					next_lk.weight_q = !lk.weight_q;
				end
				case (lk.mode_s2)
				pcd_pkg::PCD_LCD: begin
					next_lk.wgt = next_lk.weight_q;
					next_lk.ftb = next_lk.frame_odd;
					next_lk.lo = pix.lower;
				end
				pcd_pkg::PCD_PLASMA: begin
					next_lk.wgt = act_n;
					next_lk.ftb = 1'b0;
					next_lk.lo = 4'h0;
				end
				pcd_pkg::PCD_CRT: begin
					next_lk.wgt = 1'b0;
					next_lk.ftb = !act_n;
					next_lk.lo = pix.lower;
				end
				default: begin
					next_lk.wgt = 1'b0;
					next_lk.ftb = 1'b0;
					next_lk.lo = 4'h0;
				end
				endcase
				next_lk.up = pix.upper;
				next_lk.bit9 = pix.bit9;
			end
			// tft borrows the read strobe pin for pixel bit 9; the new
			// bit keeps it in step with the nibbles, off the sample edge
			next_lk.prd_n = lk.tft_s2 ?
				next_lk.bit9 : !lk.rd_s2;
		end
	end

	always_ff @(posedge i_link_clk) begin
		lk <= next_lk;
	end

	// outputs straight from flops
	assign o_pix_ready = fifo_ready;
	assign o_stat_valid = s.rvalid;
	assign o_stat_data = s.rdata;
	assign o_display_type_select = s.type_sel;
	assign o_palette_write_n = s.wr_n;
	assign o_column_shift_clock = lk.sck;
	assign o_gray_weight_clock = lk.wgt;
	assign o_line_latch_hsync = lk.latch;
	assign o_frame_start_vsync = lk.fpv;
	assign o_frame_toggle_blank = lk.ftb;
	assign o_lower_half_data = lk.lo;
	assign o_upper_half_data = lk.up;
	assign o_pixel_clock = lk.pclk;
	assign o_palette_read_n = lk.prd_n;
endmodule : pcd_port

// ### inc/pcd_cfg.svh
// constants for the panel and crt display port
`ifndef PCD_CFG_SVH
`define PCD_CFG_SVH
`define PCD_ADDR_W 16
`define PCD_DAC_MASK 16'h03c6
`define PCD_DAC_RINDEX 16'h03c7
`define PCD_DAC_WINDEX 16'h03c8
`define PCD_DAC_DATA 16'h03c9
`define PCD_IN_STAT0 16'h03c2
`define PCD_SENSE_BIT 4
`define PCD_CNT_W 12
`define PCD_CNT_ONE 12'h001
`define PCD_H_ACT 12'h280
`define PCD_H_TOT 12'h320
`define PCD_HS_START 12'h290
`define PCD_HS_LEN 12'h060
`define PCD_V_ACT 12'h1e0
`define PCD_V_TOT 12'h20d
`define PCD_VS_START 12'h1ea
`define PCD_VS_LEN 12'h002
`define PCD_PIX_W 9
`define PCD_FIFO_DEPTH 32
`endif

// ### inc/pcd_pkg.sv
// types shared by the panel and crt display port
`include "pcd_cfg.svh"
package pcd_pkg;
	// display modes, gray coded lcd -> plasma -> crt
	typedef enum logic [1:0] {
		PCD_LCD = 2'h0,
		PCD_PLASMA = 2'h1,
		PCD_CRT = 2'h3
	} pcd_mode_t;

	// one pixel word as it travels through the fifo
	typedef struct packed {
		logic bit9;
		logic [3:0] upper;
		logic [3:0] lower;
	} pcd_pix_t;

	// state on the system clock
	typedef struct packed {
		logic rst_q;
		logic ce_q;
		logic vref_s1;
		logic vref_s2;
		logic sense_s1;
		logic sense_s2;
		logic rd_hit;
		logic wr_n;
		logic type_sel;
		pcd_mode_t mode_q;
		logic tft_q;
		logic rvalid;
		logic [7:0] rdata;
	} pcd_sys_t;

	// state on the link clock
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic ce_s1;
		logic ce_s2;
		pcd_mode_t mode_s1;
		pcd_mode_t mode_s2;
		logic tft_s1;
		logic tft_s2;
		logic ref_s1;
		logic ref_s2;
		logic rd_s1;
		logic rd_s2;
		logic [`PCD_CNT_W-1:0] hcnt;
		logic [`PCD_CNT_W-1:0] vcnt;
		logic phase;
		logic act;
		logic frame_odd;
		logic weight_q;
		logic sck;
		logic pclk;
		logic wgt;
		logic latch;
		logic fpv;
		logic ftb;
		logic [3:0] up;
		logic [3:0] lo;
		logic bit9;
		logic prd_n;
	} pcd_link_t;
endpackage : pcd_pkg

// ### tb/pcd_port_sva.sv
// assertions on the display port pins
`include "pcd_cfg.svh"
module pcd_port_sva (
	// clocks, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_link_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// configuration and host cycle
	input wire pcd_pkg::pcd_mode_t i_display_mode,
	input wire logic i_refresh_disable_n,
	input wire logic [`PCD_ADDR_W-1:0] i_io_addr,
	input wire logic i_io_rd,
	input wire logic i_io_wr,
	// outputs watched
	input wire logic o_stat_valid,
	input wire logic [7:0] o_stat_data,
	input wire logic o_display_type_select,
	input wire logic o_column_shift_clock,
	input wire logic o_pixel_clock,
	input wire logic o_line_latch_hsync,
	input wire logic o_frame_start_vsync,
	input wire logic o_frame_toggle_blank,
	input wire logic [3:0] o_upper_half_data,
	input wire logic [3:0] o_lower_half_data,
	input wire logic o_palette_write_n
);
	wr_strobe_a:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && i_io_wr && i_io_addr inside {[16'h03c6:16'h03c9]}
		|=> !o_palette_write_n) else $error("write strobe missing");
	wr_idle_a:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && !i_io_wr |=> o_palette_write_n)
		else $error("write strobe without write");
	type_crt_a:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_display_mode == pcd_pkg::PCD_CRT)[*3] |-> o_display_type_select)
		else $error("display type low in crt mode");
	stat_pulse_a:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && i_io_rd && i_io_addr == 16'h03c2 |=> o_stat_valid &&
		o_stat_data[7:5] == 3'h0 && o_stat_data[3:0] == 4'h0)
		else $error("status read wrong");
	stat_idle_a:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && !(i_io_rd && i_io_addr == 16'h03c2) |=> !o_stat_valid)
		else $error("status valid without read");
	sck_pulse_a:
	assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
		$rose(o_column_shift_clock) |=> !o_column_shift_clock)
		else $error("shift clock pulse too long");
	pclk_pulse_a:
	assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
		$rose(o_pixel_clock) |=> !o_pixel_clock)
		else $error("pixel clock pulse too long");
	data_stable_a:
	assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
		$rose(o_column_shift_clock) || $rose(o_pixel_clock) |->
		$stable(o_upper_half_data) && $stable(o_lower_half_data))
		else $error("data moved at sampling edge");
	refresh_off_a:
	assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
		(!i_refresh_disable_n)[*6] |-> !o_column_shift_clock &&
		!o_line_latch_hsync && !o_pixel_clock)
		else $error("raster runs while refresh off");
	ftb_align_a:
	assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
		(i_display_mode == pcd_pkg::PCD_LCD)[*8] ##4
		(i_display_mode == pcd_pkg::PCD_LCD &&
		$changed(o_frame_toggle_blank)) |-> $rose(o_frame_start_vsync))
		else $error("frame toggle off frame pulse");
endmodule : pcd_port_sva

bind pcd_port pcd_port_sva u_sva (
	.i_sys_clk(i_sys_clk), .i_link_clk(i_link_clk), .i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en), .i_display_mode(i_display_mode),
	.i_refresh_disable_n(i_refresh_disable_n), .i_io_addr(i_io_addr),
	.i_io_rd(i_io_rd), .i_io_wr(i_io_wr), .o_stat_valid(o_stat_valid),
	.o_stat_data(o_stat_data),
	.o_display_type_select(o_display_type_select),
	.o_column_shift_clock(o_column_shift_clock),
	.o_pixel_clock(o_pixel_clock), .o_line_latch_hsync(o_line_latch_hsync),
	.o_frame_start_vsync(o_frame_start_vsync),
	.o_frame_toggle_blank(o_frame_toggle_blank),
	.o_upper_half_data(o_upper_half_data),
	.o_lower_half_data(o_lower_half_data),
	.o_palette_write_n(o_palette_write_n)
);

// ### tb/pcd_panel_model.sv
// panel column driver model, takes words on the shift clock
module pcd_panel_model (
	// panel pins
	input wire logic i_link_clk,
	input wire logic i_sck,
	input wire logic i_latch,
	input wire logic i_bit9,
	input wire logic [3:0] i_up,
	input wire logic [3:0] i_lo
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] cap_q[$];
	int line_q[$];
	int n_sck = 0;
	logic lat_d = 1'b0;
	// sample on the falling link edge, well clear of data changes
	always @(negedge i_link_clk) begin
		if (i_sck === 1'b1) begin
			cap_q.push_back({i_bit9, i_up, i_lo});
			n_sck++;
		end
		if (i_latch === 1'b1 && !lat_d) begin
			line_q.push_back(n_sck);
			n_sck = 0;
		end
		lat_d = i_latch;
	end
endmodule : pcd_panel_model

// ### tb/testbench.sv
// self-checking bench for the display port
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n, clk_en, tft, ref_n, vref, sense, rd, wr, pvalid, s;
	logic [15:0] addr;
	pcd_pkg::pcd_mode_t mode;
	pcd_pkg::pcd_pix_t pix;
	logic stat_v, pready, type_sel, sck, wgt, lat, fpv, ftb, pclk, prd_n;
	logic pwr_n, g;
	logic [5:0] seen;
	logic [7:0] stat_d;
	logic [3:0] lo, up;
	logic [8:0] exp_q[$];
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	// short raster so a frame lasts about seventy system cycles
	pcd_port #(.H_ACT(12'h008), .H_TOT(12'h00c), .HS_START(12'h009),
		.HS_LEN(12'h002), .V_ACT(12'h004), .V_TOT(12'h006),
		.VS_START(12'h004), .VS_LEN(12'h001), .FIFO_DEPTH(32)) u_dut (
		.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
		.i_link_clk(link_clk), .i_display_mode(mode), .i_color_tft(tft),
		.i_refresh_disable_n(ref_n), .i_vref_grounded(vref),
		.i_monitor_sense_scale_adj(sense), .i_io_addr(addr),
		.i_io_rd(rd), .i_io_wr(wr), .o_stat_valid(stat_v),
		.o_stat_data(stat_d), .i_pix_valid(pvalid), .i_pix(pix),
		.o_pix_ready(pready), .o_display_type_select(type_sel),
		.o_column_shift_clock(sck), .o_gray_weight_clock(wgt),
		.o_line_latch_hsync(lat), .o_frame_start_vsync(fpv),
		.o_frame_toggle_blank(ftb), .o_lower_half_data(lo),
		.o_upper_half_data(up), .o_pixel_clock(pclk),
		.o_palette_read_n(prd_n), .o_palette_write_n(pwr_n));
	pcd_panel_model u_panel (.i_link_clk(link_clk), .i_sck(sck),
		.i_latch(lat), .i_bit9(prd_n), .i_up(up), .i_lo(lo));
	// clocks, the link one offset so the phases never line up
	always #50 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	task automatic chk_pin(input logic got, input logic exp, input string w);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s: got %b want %b", $time, w, got, exp);
		end
	endtask : chk_pin
	task automatic chk_val(input logic [8:0] got, input logic [8:0] exp,
		input string w);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s: got %h want %h", $time, w, got, exp);
		end
	endtask : chk_val
	task end_sim;
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	// hang guard, the whole run needs about 1200 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			$display("[ERR] %0t run timed out", $time);
			end_sim();
		end
	end
	initial begin
		logic [8:0] w;
		int n;
		rst_n = 1'b0;
		clk_en = 1'b1;
		tft = 1'b1;
		ref_n = 1'b0;
		vref = 1'b0;
		sense = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		pvalid = 1'b0;
		addr = 16'h0000;
		mode = pcd_pkg::PCD_LCD;
		pix = '0;
		void'($urandom(32'h5fb9cc6d));
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		// fill while refresh is held off, random gaps in valid
		for (int i = 0; i < 120; i++) begin
			w = 9'($urandom);
			g = 1'($urandom);
			pix <= w;
			pvalid <= g;
			@(posedge sys_clk);
			if (g && pready === 1'b1) exp_q.push_back(w);
		end
		pvalid <= 1'b0;
		chk_val(9'(exp_q.size()), 9'h020, "words held");
		ref_n <= 1'b1;
		n = 0;
		while (u_panel.cap_q.size() < 32 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		// let the latch of the last filled line arrive
		repeat (10) @(posedge sys_clk);
		for (int i = 0; i < 32; i++) begin
			chk_val(u_panel.cap_q[i], exp_q[i], "panel word");
		end
		chk_pin(u_panel.line_q.size() > 3, 1'b1, "lines latched");
		foreach (u_panel.line_q[i]) begin
			chk_pin(u_panel.line_q[i] inside {0, 8}, 1'b1, "line");
		end
		// strobe decode with and without the internal dac
		tft <= 1'b0;
		for (int v = 0; v < 2; v++) begin
			s = 1'($urandom);
			vref <= v[0];
			sense <= s;
			for (int a = 'h3c1; a < 'h3cb; a++) begin
				addr <= 16'(a);
				rd <= 1'b0;
				wr <= 1'b1;
				repeat (2) @(posedge sys_clk);
				chk_pin(pwr_n, !(a inside {['h3c6:'h3c9]}), "write");
				wr <= 1'b0;
				rd <= 1'b1;
				repeat (5) @(posedge sys_clk);
				chk_pin(prd_n, !(a inside {'h3c6, 'h3c8, 'h3c9}), "read");
				chk_pin(stat_v, a == 'h3c2, "status valid");
				if (a == 'h3c2) chk_val({1'b0, stat_d}, {4'h0, s & v[0], 4'h0}, "status");
			end
			rd <= 1'b0;
		end
		// a few frames in each mode, fed with random pixels
		pvalid <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			if (m != 2) begin
				mode <= pcd_pkg::pcd_mode_t'(m);
				seen = '0;
				repeat (20) @(posedge sys_clk);
				repeat (180) begin
					pix <= 9'($urandom);
					@(posedge sys_clk);
					seen = seen | {fpv, sck, pclk, wgt, ftb, |lo};
				end
				chk_pin(type_sel, m == 3, "display type");
				chk_pin(seen[5], 1'b1, "frame pulse");
				chk_pin(seen[4], m != 3, "shift clock");
				chk_pin(seen[3], m == 3, "pixel clock");
				chk_pin(seen[2], m != 3, "weight clock");
				chk_pin(seen[1], m != 1, "frame toggle");
				chk_pin(seen[0], m != 1, "lower data");
			end
		end
		pvalid <= 1'b0;
		mode <= pcd_pkg::PCD_LCD;
		ref_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		n = u_panel.cap_q.size();
		repeat (200) @(posedge sys_clk);
		chk_val(9'(u_panel.cap_q.size() - n), 9'h000, "shift while off");
		// a write offered while gated must leave the strobe as it was
		addr <= 16'h03c8;
		for (int i = 0; i < 6; i++) begin
			g = 1'($urandom);
			clk_en <= g;
			wr <= 1'b1;
			repeat (2) @(posedge sys_clk);
			chk_pin(pwr_n, !g, "write while gated");
			clk_en <= 1'b1;
			wr <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk_pin(pwr_n, 1'b1, "write released");
		end
		end_sim();
	end
endmodule : testbench
